// file: overlap_pkg.sv
/*
  Shared constants and types for the instruction overlap fetch block:
  word layout, store geometry, decode values and sequencer states.
  Assumes a 36-bit word numbered S,1..35 with S as the most significant bit.
*/
package overlap_pkg;

  localparam int WORD_W = 36;
  localparam int ADDR_W = 15;
  localparam int HALF_W = 14;
  localparam int TAG_W = 3;
  localparam int OP_W = 12;
  localparam int STORE_WORDS = 32768;
  localparam int HALF_WORDS = 16384;

  // Field positions, written as bit indices with S at bit 35
  localparam int ADDR_LSB = 0;
  localparam int TAG_LSB = 15;
  localparam int FLAG_LSB = 22;
  localparam int OP_LSB = 24;

  // Low address bit picks the store half, the rest address the word in it
  localparam int HALF_SEL_BIT = 0;
  localparam int WITHIN_LSB = 1;

  // Indirect flag value in bits 12-13
  localparam logic [1:0] INDIRECT_FLAG = 2'h3;
  localparam logic [TAG_W-1:0] TAG_NONE = 3'h0;
  localparam logic [TAG_W-1:0] TAG_ONE = 3'h1;
  localparam logic [TAG_W-1:0] TAG_TWO = 3'h2;
  localparam logic [TAG_W-1:0] TAG_FOUR = 3'h4;

  // Decode group seventy eight and its shift subset, octal 0760 style
  localparam logic [5:0] GROUP_78_CODE = 6'h3E;
  localparam logic [OP_W-1:0] SHIFT_MASK = 12'hE00;
  localparam logic [OP_W-1:0] SHIFT_CODE = 12'h600;

  localparam logic [ADDR_W-1:0] START_ADDR = 15'h0000;
  localparam logic [WORD_W-1:0] WORD_ZERO = 36'h000000000;

  typedef logic [WORD_W-1:0] word_t;
  typedef logic [ADDR_W-1:0] addr_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_FETCH_PAIR = 6'h02,
    ST_WAIT_PAIR = 6'h04,
    ST_INDIRECT = 6'h08,
    ST_EXECUTE = 6'h10,
    ST_WAIT_NEXT = 6'h20
  } seq_state_t;

  // Field extraction used by both the address former and the sequencer
  function automatic addr_t addr_field(input word_t w);
    return w[ADDR_LSB +: ADDR_W];
  endfunction : addr_field

  function automatic logic [TAG_W-1:0] tag_field(input word_t w);
    return w[TAG_LSB +: TAG_W];
  endfunction : tag_field

  function automatic logic is_indirect(input word_t w);
    return w[FLAG_LSB +: 2] == INDIRECT_FLAG;
  endfunction : is_indirect

  // Half of the split store that holds an address
  function automatic logic half_of(input addr_t a);
    return a[HALF_SEL_BIT];
  endfunction : half_of

endpackage : overlap_pkg

// file: store_port_if.sv
/*
  Interface between the sequencer and the two-port store requester.
  Assumes one request per half at a time.
*/
`timescale 1ns/1ps
interface store_port_if;
  import overlap_pkg::*;
  logic req_valid;
  addr_t req_addr_a;
  addr_t req_addr_b;
  logic req_pair;
  logic rsp_valid;
  word_t rsp_word_a;
  word_t rsp_word_b;

  modport seq (output req_valid, req_addr_a, req_addr_b, req_pair,
               input rsp_valid, rsp_word_a, rsp_word_b);
  modport port (input req_valid, req_addr_a, req_addr_b, req_pair,
                output rsp_valid, rsp_word_a, rsp_word_b);
endinterface : store_port_if

// file: store_port.sv
/*
  Steers one or two word requests onto the two independent store halves
  and collects the answers. Assumes each half answers with its valid
  strobe and holds no request open beyond its acknowledge.
*/
`timescale 1ns/1ps
module store_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Sequencer side
  store_port_if.port sp,
  // Half zero
  output logic half0_req,
  output logic [overlap_pkg::HALF_W-1:0] half0_addr,
  input wire logic half0_ack,
  input wire logic [overlap_pkg::WORD_W-1:0] half0_data,
  // Half one
  output logic half1_req,
  output logic [overlap_pkg::HALF_W-1:0] half1_addr,
  input wire logic half1_ack,
  input wire logic [overlap_pkg::WORD_W-1:0] half1_data
);
  import overlap_pkg::*;

  logic busy_q;
  logic pair_q;
  logic a_half_q;
  logic need0_q, need1_q;
  logic got0_q, got1_q;
  word_t w0_q, w1_q;
  addr_t a_q, b_q;

  assign half0_req = busy_q && need0_q && !got0_q;
  assign half1_req = busy_q && need1_q && !got1_q;
  assign half0_addr = (half_of(a_q) == 1'b0) ? a_q[WITHIN_LSB +: HALF_W] :
                      b_q[WITHIN_LSB +: HALF_W];
  assign half1_addr = (half_of(a_q) == 1'b1) ? a_q[WITHIN_LSB +: HALF_W] :
                      b_q[WITHIN_LSB +: HALF_W];

  // Consecutive addresses always fall in opposite halves
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      pair_q <= 1'b0;
      a_half_q <= 1'b0;
      need0_q <= 1'b0;
      need1_q <= 1'b0;
      got0_q <= 1'b0;
      got1_q <= 1'b0;
      w0_q <= WORD_ZERO;
      w1_q <= WORD_ZERO;
      a_q <= START_ADDR;
      b_q <= START_ADDR;
    end else if (!busy_q) begin
      got0_q <= 1'b0;
      got1_q <= 1'b0;
      if (sp.req_valid) begin
        busy_q <= 1'b1;
        pair_q <= sp.req_pair;
        a_q <= sp.req_addr_a;
        b_q <= sp.req_addr_b;
        a_half_q <= half_of(sp.req_addr_a);
        need0_q <= !half_of(sp.req_addr_a) || sp.req_pair;
        need1_q <= half_of(sp.req_addr_a) || sp.req_pair;
      end
    end else begin
      if (half0_req && half0_ack) begin
        got0_q <= 1'b1;
        w0_q <= half0_data;
      end
      if (half1_req && half1_ack) begin
        got1_q <= 1'b1;
        w1_q <= half1_data;
      end
      if (sp.rsp_valid) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign sp.rsp_valid = busy_q && (got0_q || !need0_q) && (got1_q || !need1_q);
  assign sp.rsp_word_a = a_half_q ? w1_q : w0_q;
  assign sp.rsp_word_b = pair_q ? (a_half_q ? w0_q : w1_q) : WORD_ZERO;

endmodule : store_port

// file: addr_former.sv
/*
  Combinational effective address former: subtracts the selected index
  registers from an address field. Assumes index contents are stable.
*/
`timescale 1ns/1ps
module addr_former (
  // Operand word
  input wire logic [overlap_pkg::WORD_W-1:0] word_in,
  // Index registers
  input wire logic [overlap_pkg::ADDR_W-1:0] index_register_one,
  input wire logic [overlap_pkg::ADDR_W-1:0] index_register_two,
  input wire logic [overlap_pkg::ADDR_W-1:0] index_register_four,
  // Result
  output logic [overlap_pkg::ADDR_W-1:0] eff_addr
);
  import overlap_pkg::*;

  logic [TAG_W-1:0] tag;
  addr_t sel;

  // Tag bits select index registers, several selected ones are ORed
  always_comb begin
    tag = tag_field(word_in);
    sel = '0;
    if ((tag & TAG_ONE) != TAG_NONE) sel = sel | index_register_one;
    if ((tag & TAG_TWO) != TAG_NONE) sel = sel | index_register_two;
    if ((tag & TAG_FOUR) != TAG_NONE) sel = sel | index_register_four;
    if (tag == TAG_NONE) begin
      eff_addr = addr_field(word_in);
    end else begin
      eff_addr = addr_field(word_in) - sel;
    end
  end

endmodule : addr_former

// file: instruction_overlap_fetch.sv
/*
  Instruction fetch, address formation and overlap sequencing for a
  36-bit processor with a store split into two independent halves.
  Assumes the execute unit signals completion with exec_done and any
  trap with trap_req; index registers are supplied from outside.
*/
// Operation
// - An indexed instruction's effective address is its address field minus the chosen index.
// - An indirect instruction reads the word at the effective address and uses its address.
// - A tagged indirect word has its selected index subtracted to give the operand address.
// - The store is two independent halves of 16,384 words, so neighbours come from both.
// - Double overlap loads the first word into the program register, the next into backup.
// - Backup instruction analysis and modification run while the current one executes.
// - On completion the backup word moves into both program and storage registers.
// - The first word of a pair may sit at an odd or an even address.
// - In extended overlap each handover also fetches the next sequential word into backup.
// - Handovers continue for as long as nothing breaks the overlap.
// - Backup word indexing is done during backup instruction time; its indirect cycle waits until after handover.
// - Traps, double precision, one-cycle and group 78 non-shift words break overlap.
// - Double overlap is used at start and after a break before extended overlap resumes.
// - The direct address is taken from bits 21 to 35 of the word.
// - The tag field selects the index register used for modification.
`timescale 1ns/1ps
module instruction_overlap_fetch (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  input wire logic exec_done,
  input wire logic trap_req,
  input wire logic [overlap_pkg::ADDR_W-1:0] trap_addr,
  input wire logic transfer_taken,
  input wire logic [overlap_pkg::ADDR_W-1:0] transfer_addr,
  input wire logic double_precision,
  input wire logic one_cycle,
  // Index registers
  input wire logic [overlap_pkg::ADDR_W-1:0] index_register_one,
  input wire logic [overlap_pkg::ADDR_W-1:0] index_register_two,
  input wire logic [overlap_pkg::ADDR_W-1:0] index_register_four,
  // Store half zero
  output logic half0_req,
  output logic [overlap_pkg::HALF_W-1:0] half0_addr,
  input wire logic half0_ack,
  input wire logic [overlap_pkg::WORD_W-1:0] half0_data,
  // Store half one
  output logic half1_req,
  output logic [overlap_pkg::HALF_W-1:0] half1_addr,
  input wire logic half1_ack,
  input wire logic [overlap_pkg::WORD_W-1:0] half1_data,
  // Execute side
  output logic [overlap_pkg::WORD_W-1:0] program_register,
  output logic [overlap_pkg::WORD_W-1:0] storage_register,
  output logic [overlap_pkg::ADDR_W-1:0] operand_addr,
  output logic exec_start,
  output logic backup_valid,
  output logic [overlap_pkg::WORD_W-1:0] instruction_backup_register,
  output logic [overlap_pkg::ADDR_W-1:0] backup_operand_addr,
  output logic backup_instruction_time,
  output logic extended_mode,
  output logic [overlap_pkg::ADDR_W-1:0] instr_counter
);
  import overlap_pkg::*;

  // ********************************************************
  // Storage and state
  // ********************************************************
  store_port_if sp ();

  seq_state_t state_q;
  word_t prog_q, stor_q, backup_q;
  logic backup_valid_q, ext_q, exec_start_q, ind_pending_q, bk_ind_q;
  addr_t pc_q, op_addr_q, bk_addr_q;

  addr_t first_ea, bk_ea, ind_ea;
  logic breaks_now;

  store_port u_store_port (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sp(sp),
    .half0_req(half0_req),
    .half0_addr(half0_addr),
    .half0_ack(half0_ack),
    .half0_data(half0_data),
    .half1_req(half1_req),
    .half1_addr(half1_addr),
    .half1_ack(half1_ack),
    .half1_data(half1_data)
  );

  // ********************************************************
  // Address formation
  // ********************************************************
  addr_former u_ea_first (
    .word_in(sp.rsp_word_a),
    .index_register_one(index_register_one),
    .index_register_two(index_register_two),
    .index_register_four(index_register_four),
    .eff_addr(first_ea)
  );

  // Backup word modified during backup instruction time
  addr_former u_ea_backup (
    .word_in(backup_q),
    .index_register_one(index_register_one),
    .index_register_two(index_register_two),
    .index_register_four(index_register_four),
    .eff_addr(bk_ea)
  );

  addr_former u_ea_ind (
    .word_in(sp.rsp_word_a),
    .index_register_one(index_register_one),
    .index_register_two(index_register_two),
    .index_register_four(index_register_four),
    .eff_addr(ind_ea)
  );

  // ********************************************************
  // Overlap break decode
  // ********************************************************
  function automatic logic breaks_overlap(input word_t w, input logic dp, input logic oc);
    logic grp;
    logic shift;
    grp = w[OP_LSB + 6 +: 6] == GROUP_78_CODE;
    shift = (w[OP_LSB +: OP_W] & SHIFT_MASK) == SHIFT_CODE;
    return dp || oc || (grp && !shift);
  endfunction : breaks_overlap

  assign breaks_now = trap_req || transfer_taken ||
                      breaks_overlap(prog_q, double_precision, one_cycle);

  // ********************************************************
  // Store requests
  // ********************************************************
  always_comb begin
    sp.req_valid = 1'b0;
    sp.req_pair = 1'b0;
    sp.req_addr_a = pc_q;
    sp.req_addr_b = ADDR_W'(pc_q + 1'b1);
    case (state_q)
      ST_FETCH_PAIR: begin
        sp.req_valid = 1'b1;
        sp.req_pair = 1'b1;
      end
      ST_INDIRECT: begin
        sp.req_valid = !ind_pending_q;
        sp.req_addr_a = bk_ind_q ? bk_addr_q : op_addr_q;
      end
      ST_WAIT_NEXT: begin
        sp.req_valid = 1'b1;
        sp.req_addr_a = pc_q;
      end
      default: begin
        sp.req_valid = 1'b0;
      end
    endcase
  end

  // ********************************************************
  // Sequencer
  // ********************************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      prog_q <= WORD_ZERO;
      stor_q <= WORD_ZERO;
      backup_q <= WORD_ZERO;
      backup_valid_q <= 1'b0;
      ext_q <= 1'b0;
      exec_start_q <= 1'b0;
      ind_pending_q <= 1'b0;
      bk_ind_q <= 1'b0;
      pc_q <= START_ADDR;
      op_addr_q <= START_ADDR;
      bk_addr_q <= START_ADDR;
    end else begin
      exec_start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (run) begin
            ext_q <= 1'b0;
            state_q <= ST_FETCH_PAIR;
          end
        end
        ST_FETCH_PAIR: begin
          state_q <= ST_WAIT_PAIR;
        end
        ST_WAIT_PAIR: begin
          if (sp.rsp_valid) begin
            prog_q <= sp.rsp_word_a;
            stor_q <= sp.rsp_word_a;
            backup_q <= sp.rsp_word_b;
            backup_valid_q <= 1'b1;
            pc_q <= ADDR_W'(pc_q + 2'h2);
            op_addr_q <= first_ea;
            bk_ind_q <= 1'b0;
            if (is_indirect(sp.rsp_word_a)) begin
              state_q <= ST_INDIRECT;
            end else begin
              exec_start_q <= 1'b1;
              state_q <= ST_EXECUTE;
            end
          end
        end
        ST_INDIRECT: begin
          if (!ind_pending_q) begin
            ind_pending_q <= 1'b1;
          end else if (sp.rsp_valid) begin
            ind_pending_q <= 1'b0;
            exec_start_q <= 1'b1;
            state_q <= ST_EXECUTE;
            if (bk_ind_q) begin
              bk_addr_q <= ind_ea;
            end else begin
              op_addr_q <= ind_ea;
            end
          end
        end
        ST_EXECUTE: begin
          if (!bk_ind_q) begin
            bk_addr_q <= bk_ea;
          end
          if (exec_done) begin
            if (breaks_now || !backup_valid_q) begin
              backup_valid_q <= 1'b0;
              pc_q <= trap_req ? trap_addr :
                      (transfer_taken ? transfer_addr : ADDR_W'(pc_q - 1'b1));
              ext_q <= 1'b0;
              state_q <= ST_FETCH_PAIR;
            end else begin
              prog_q <= backup_q;
              stor_q <= backup_q;
              op_addr_q <= bk_ea;
              backup_valid_q <= 1'b0;
              ext_q <= 1'b1;
              bk_ind_q <= 1'b0;
              state_q <= ST_WAIT_NEXT;
              if (!is_indirect(backup_q)) begin
                exec_start_q <= 1'b1;
              end
            end
          end
        end
        ST_WAIT_NEXT: begin
          if (sp.rsp_valid) begin
            backup_q <= sp.rsp_word_a;
            backup_valid_q <= 1'b1;
            pc_q <= ADDR_W'(pc_q + 1'b1);
            if (is_indirect(prog_q)) begin
              state_q <= ST_INDIRECT;
            end else begin
              state_q <= ST_EXECUTE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign program_register = prog_q;
  assign storage_register = stor_q;
  assign operand_addr = op_addr_q;
  assign exec_start = exec_start_q;
  assign backup_valid = backup_valid_q;
  assign instruction_backup_register = backup_q;
  assign backup_operand_addr = bk_addr_q;
  assign backup_instruction_time = backup_valid_q && (state_q == ST_EXECUTE);
  assign extended_mode = ext_q;
  assign instr_counter = pc_q;

endmodule : instruction_overlap_fetch

// file: split_store_model.sv
/*
  Behavioural model of the store split into two independent halves.
  Assumes requests stand until acknowledged; slow adds two wait cycles.
*/
`timescale 1ns/1ps
module split_store_model import overlap_pkg::*; (
  // Clock and pace
  input wire logic ref_clk,
  input wire logic slow,
  // Half zero
  input wire logic half0_req,
  input wire logic [HALF_W-1:0] half0_addr,
  output logic half0_ack,
  output logic [WORD_W-1:0] half0_data,
  // Half one
  input wire logic half1_req,
  input wire logic [HALF_W-1:0] half1_addr,
  output logic half1_ack,
  output logic [WORD_W-1:0] half1_data
);
  word_t mem [0:STORE_WORDS-1];
  logic [1:0] req;
  logic [1:0] ack_q = 2'h0;
  logic [HALF_W-1:0] adr [2];
  word_t dat_q [2] = '{36'h0, 36'h0};
  logic [1:0] cnt_q [2] = '{2'h0, 2'h0};
  initial begin
    for (int i = 0; i < STORE_WORDS; i++) mem[i] = {12'h040, 9'h000, 15'(i)};
  end
  assign req = {half1_req, half0_req};
  assign adr[0] = half0_addr;
  assign adr[1] = half1_addr;
  assign {half1_ack, half0_ack} = ack_q;
  assign half0_data = dat_q[0];
  assign half1_data = dat_q[1];
  always_ff @(posedge ref_clk) begin
    for (int h = 0; h < 2; h++) begin
      if (req[h] && !ack_q[h] && cnt_q[h] >= (slow ? 2'h2 : 2'h0)) begin
        ack_q[h] <= 1'b1;
        dat_q[h] <= mem[{adr[h], h[0]}];
        cnt_q[h] <= 2'h0;
      end else begin
        ack_q[h] <= 1'b0;
        // Idle bus alternates between the last word and its complement
        dat_q[h] <= ~dat_q[h];
        cnt_q[h] <= req[h] ? cnt_q[h] + 2'h1 : 2'h0;
      end
    end
  end
endmodule : split_store_model

// file: overlap_asserts.sv
/*
  Concurrent checks on the overlap fetch block's ports.
  Assumes index registers hold still while instructions are in flight.
*/
`timescale 1ns/1ps
module overlap_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Control
  input wire logic exec_done,
  input wire logic trap_req,
  input wire logic transfer_taken,
  input wire logic double_precision,
  input wire logic one_cycle,
  // Index registers
  input wire logic [overlap_pkg::ADDR_W-1:0] index_register_one,
  input wire logic [overlap_pkg::ADDR_W-1:0] index_register_two,
  input wire logic [overlap_pkg::ADDR_W-1:0] index_register_four,
  // Store
  input wire logic half0_req,
  input wire logic [overlap_pkg::HALF_W-1:0] half0_addr,
  input wire logic half0_ack,
  input wire logic half1_req,
  // Execute side
  input wire logic [overlap_pkg::WORD_W-1:0] program_register,
  input wire logic [overlap_pkg::WORD_W-1:0] storage_register,
  input wire logic [overlap_pkg::ADDR_W-1:0] operand_addr,
  input wire logic exec_start,
  input wire logic backup_valid,
  input wire logic [overlap_pkg::WORD_W-1:0] instruction_backup_register,
  input wire logic [overlap_pkg::ADDR_W-1:0] backup_operand_addr,
  input wire logic backup_instruction_time,
  input wire logic extended_mode
);
  import overlap_pkg::*;
  // ****************
  // Helpers
  // ****************
  function automatic logic [14:0] ea(input logic [35:0] w);
    logic [14:0] sel;
    sel = (w[15] ? index_register_one : 15'h0000) | (w[16] ? index_register_two : 15'h0000)
      | (w[17] ? index_register_four : 15'h0000);
    return w[14:0] - sel;
  endfunction : ea
  function automatic logic g78(input logic [35:0] w);
    return w[35:30] == 6'h3E && (w[35:24] & 12'hE00) != 12'h600;
  endfunction : g78
  logic hand;
  logic cut;
  assign cut = exec_done && backup_instruction_time
    && (trap_req || double_precision || one_cycle || g78(program_register));
  assign hand = exec_done && backup_instruction_time && !cut && !transfer_taken
    && !g78(instruction_backup_register);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ****************
  // Properties
  // ****************
  property p_handover;
    hand |=> program_register == $past(instruction_backup_register)
      && storage_register == $past(instruction_backup_register);
  endproperty
  a_handover: assert property (p_handover)
    else $error("backup word not handed to program and storage registers");
  property p_extend;
    hand |=> extended_mode ##[0:2] (half0_req || half1_req);
  endproperty
  a_extend: assert property (p_extend)
    else $error("handover without extended mode and next fetch");
  property p_break;
    cut |=> !extended_mode && !backup_valid ##[0:3] (half0_req || half1_req);
  endproperty
  a_break: assert property (p_break)
    else $error("break did not discard backup and refetch");
  property p_index;
    exec_start && program_register[23:22] != 2'h3 |-> operand_addr == ea(program_register);
  endproperty
  a_index: assert property (p_index)
    else $error("effective address wrong at start");
  property p_double;
    exec_start && !extended_mode |-> backup_valid;
  endproperty
  a_double: assert property (p_double)
    else $error("double overlap start without backup word");
  property p_prelim;
    hand && instruction_backup_register[23:22] != 2'h3
      |-> backup_operand_addr == ea(instruction_backup_register);
  endproperty
  a_prelim: assert property (p_prelim)
    else $error("backup word not modified before handover");
  property p_bk_time;
    backup_instruction_time |-> backup_valid;
  endproperty
  a_bk_time: assert property (p_bk_time)
    else $error("backup time without backup word");
  property p_hold0;
    half0_req && !half0_ack |=> half0_req && $stable(half0_addr);
  endproperty
  a_hold0: assert property (p_hold0)
    else $error("half zero request dropped or moved before answer");
  c_handover: cover property (hand);
  c_break: cover property (cut);
  c_double: cover property (exec_start && !extended_mode);
endmodule : overlap_asserts

bind instruction_overlap_fetch overlap_asserts chk (.*);

// file: testbench.sv
/*
  Scenario testbench for the overlap fetch block.
  Assumes the split store model and the port checker beside it.
*/
`timescale 1ns/1ps
module testbench;
  import overlap_pkg::*;
  // ****************
  // Signals
  // ****************
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic run = 1'b0;
  logic exec_done = 1'b0;
  logic trap_req = 1'b0;
  addr_t trap_addr = 15'h0000;
  logic transfer_taken = 1'b0;
  addr_t transfer_addr = 15'h0000;
  logic double_precision = 1'b0;
  logic one_cycle = 1'b0;
  addr_t index_register_one = 15'h0002;
  addr_t index_register_two = 15'h0003;
  addr_t index_register_four = 15'h0004;
  logic half0_req, half1_req, half0_ack, half1_ack, slow;
  logic [HALF_W-1:0] half0_addr, half1_addr;
  word_t half0_data, half1_data, program_register, storage_register;
  word_t instruction_backup_register;
  addr_t operand_addr, backup_operand_addr, instr_counter;
  logic exec_start, backup_valid, backup_instruction_time, extended_mode;
  addr_t exp_oa [0:STORE_WORDS-1];
  int failures = 0;
  int checks_done = 0;

  instruction_overlap_fetch dut (.*);
  split_store_model st (.*);

  initial forever #12.5 ref_clk = ~ref_clk;
  // ****************
  // Tasks
  // ****************
  task automatic check(input word_t seen, input word_t exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  function automatic word_t mkw(logic [11:0] op, logic [1:0] fl, logic [2:0] tg, addr_t a);
    return {op, fl, 4'h0, tg, a};
  endfunction : mkw
  task automatic put(input addr_t a, input word_t w, input addr_t oa);
    st.mem[a] = w;
    exp_oa[a] = oa;
  endtask : put
  task automatic tick;
    @(posedge ref_clk);
    #2;
  endtask : tick
  task automatic await(ref logic s, input string what);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    if (n == 100) check(36'h0, 36'h1, what);
  endtask : await
  // Executes the word at pc; kind 1 trap, 2 double, 3 one cycle, 4 transfer
  task automatic step(input addr_t pc, input logic ext, input int kind, input addr_t tgt);
    await(exec_start, "no start");
    check(program_register, st.mem[pc], "program word");
    check(36'(operand_addr), 36'(exp_oa[pc]), "operand address");
    check(36'(extended_mode), 36'(ext), "overlap mode");
    if (ext) check(storage_register, st.mem[pc], "storage word");
    await(backup_valid, "no backup");
    tick();
    check(instruction_backup_register, st.mem[pc + 15'h1], "backup word");
    check(36'(backup_instruction_time), 36'h1, "backup time");
    check(36'(instr_counter), 36'(pc + 15'h2), "next fetch");
    if (st.mem[pc + 15'h1][23:22] != 2'h3)
      check(36'(backup_operand_addr), 36'(exp_oa[pc + 15'h1]), "backup address");
    exec_done = 1'b1;
    trap_req = (kind == 1);
    double_precision = (kind == 2);
    one_cycle = (kind == 3);
    transfer_taken = (kind == 4);
    trap_addr = tgt;
    transfer_addr = tgt;
    tick();
    {exec_done, trap_req, double_precision, one_cycle, transfer_taken} = 5'h00;
  endtask : step
  task automatic load_program;
    put(15'h0000, mkw(12'h040, 2'h0, 3'h0, 15'h0020), 15'h0020);
    put(15'h0001, mkw(12'h040, 2'h0, 3'h1, 15'h0030), 15'h002E);
    put(15'h0002, mkw(12'h040, 2'h0, 3'h2, 15'h0030), 15'h002D);
    put(15'h0003, mkw(12'h040, 2'h0, 3'h4, 15'h0030), 15'h002C);
    put(15'h0004, mkw(12'h040, 2'h0, 3'h3, 15'h0030), 15'h002D);
    put(15'h0100, mkw(12'h040, 2'h3, 3'h1, 15'h000A), 15'h0002);
    put(15'h0008, mkw(12'h000, 2'h0, 3'h2, 15'h0005), 15'h0008);
    put(15'h0101, mkw(12'h040, 2'h3, 3'h0, 15'h000C), 15'h0011);
    put(15'h000C, mkw(12'h000, 2'h0, 3'h0, 15'h0011), 15'h0011);
    put(15'h4001, mkw(12'hF80, 2'h0, 3'h0, 15'h0050), 15'h0050);
  endtask : load_program
  task automatic t_indexing;
    step(15'h0000, 1'b0, 0, 15'h0000);
    for (int i = 1; i < 4; i++) step(15'(i), 1'b1, 0, 15'h0000);
    step(15'h0004, 1'b1, 4, 15'h0100);
    $display("test indexing done");
  endtask : t_indexing
  task automatic t_indirect;
    step(15'h0100, 1'b0, 0, 15'h0000);
    step(15'h0101, 1'b1, 0, 15'h0000);
    step(15'h0102, 1'b1, 2, 15'h0000);
    $display("test indirect done");
  endtask : t_indirect
  task automatic t_breaks;
    step(15'h0103, 1'b0, 3, 15'h0000);
    step(15'h0104, 1'b0, 0, 15'h0000);
    step(15'h0105, 1'b1, 1, 15'h3FFF);
    $display("test breaks done");
  endtask : t_breaks
  task automatic t_split_halves;
    slow = 1'b1;
    step(15'h3FFF, 1'b0, 0, 15'h0000);
    step(15'h4000, 1'b1, 0, 15'h0000);
    step(15'h4001, 1'b1, 0, 15'h0000);
    step(15'h4002, 1'b0, 0, 15'h0000);
    step(15'h4003, 1'b1, 0, 15'h0000);
    $display("test split halves done");
  endtask : t_split_halves
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // ****************
  // Sequence
  // ****************
  initial begin
    slow = 1'b0;
    for (int i = 0; i < STORE_WORDS; i++) exp_oa[i] = 15'(i);
    repeat (6) @(posedge ref_clk);
    #2;
    sys_rst = 1'b0;
    check(36'(instr_counter), 36'(START_ADDR), "reset counter");
    check(program_register, WORD_ZERO, "reset program word");
    load_program();
    tick();
    run = 1'b1;
    t_indexing();
    t_indirect();
    t_breaks();
    t_split_halves();
    give_verdict();
  end
  initial begin
    repeat (4000) @(posedge ref_clk);
    failures++;
    give_verdict();
  end
endmodule : testbench
